// File: src/pdc_config_bank.sv
`timescale 1ns/100ps
module pdc_config_bank
  import pdc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [PDC_SEL_W-1:0] config_select_inputs,
  output logic [1:0] pll1_active_set,
  output pdc_active_t pll1_active
);

  // ****************************************
  // state
  // ****************************************
  pdc_state_t st;
  pdc_state_t next_st;

  logic [PDC_SEL_W-1:0] sel_pins;
  logic aph;
  logic mapped;
  logic [7:0] aph_idx;
  logic [1:0] pick;
  logic [PDC_FB_W-1:0] cur_n;
  logic [PDC_ADD_W-1:0] cur_a;
  logic [7:0] cur_filt;
  logic [PDC_MULT_W-1:0] cur_mult;
  logic spread_on;

  // select pins come from outside the clock domain
  pdc_sync2 #(
    .W(PDC_SEL_W)
  ) u_sel_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .d(config_select_inputs),
    .q(sel_pins)
  );

  // ****************************************
  // live set values
  // ****************************************
  // everything downstream follows the registered set index, not the pins
  assign cur_filt = st.regs.filt[st.act_set];
  assign cur_a = st.regs.add_hi[st.act_set][PDC_ADDER_LSB +: PDC_ADD_W];
  assign cur_n = {st.regs.add_hi[st.act_set][PDC_FBHI_LSB +: 4],
    st.regs.fb_lo[st.act_set]};
  assign spread_on = st.regs.ctrl[PDC_CTRL_SPREAD_EN];

  pdc_mult_calc u_calc (
    .fb_int(cur_n),
    .fb_adder(cur_a),
    .spread_en(spread_on),
    .spread_off(st.regs.spread),
    .mult(cur_mult)
  );

  // ****************************************
  // bus decode
  // ****************************************
  assign aph = hsel && htrans[1] && hready;
  assign mapped = (haddr[31:PDC_IDX_MSB+1] == '0) && (haddr[1:0] == 2'h0);
  assign aph_idx = haddr[PDC_IDX_MSB:PDC_IDX_LSB];

  // unmapped words read zero and swallow writes
  function automatic logic [31:0] pdc_read(
    input pdc_regs_t r,
    input logic [1:0] s,
    input pdc_active_t a,
    input logic [7:0] idx
  );
    logic [31:0] d;
    d = 32'h0;
    for (int i = 0; i < PDC_SETS; i++) begin
      if (idx == PDC_IDX_FILT[i]) begin
        d[7:0] = r.filt[i];
      end
      if (idx == PDC_IDX_PRE[i]) begin
        d[7:0] = r.pre[i];
      end
      if (idx == PDC_IDX_FBLO[i]) begin
        d[7:0] = r.fb_lo[i];
      end
      if (idx == PDC_IDX_ADDHI[i]) begin
        d[7:0] = r.add_hi[i];
      end
    end
    if (idx == PDC_IDX_CTRL) begin
      d[7:0] = r.ctrl;
    end
    if (idx == PDC_IDX_SPREAD) begin
      d[PDC_FRAC_W-1:0] = r.spread;
    end
    if (idx == PDC_IDX_STAT) begin
      d[PDC_MULT_W-1:0] = a.mult;
      d[PDC_STAT_SET_LSB +: 2] = s;
    end
    if (idx == PDC_IDX_STAT2) begin
      d[7:0] = a.prescaler;
      d[PDC_STAT2_FILT_LSB +: 8] = {a.pole_cap, a.zero_cap};
    end
    return d;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    pick = PDC_SET_ZERO;
    if (ce) begin
      // data phase of a write lands first so a following read sees it
      if (st.dph_wr) begin
        for (int i = 0; i < PDC_SETS; i++) begin
          if (st.dph_idx == PDC_IDX_FILT[i]) begin
            next_st.regs.filt[i] = hwdata[7:0];
          end
          if (st.dph_idx == PDC_IDX_PRE[i]) begin
            next_st.regs.pre[i] = hwdata[7:0];
          end
          if (st.dph_idx == PDC_IDX_FBLO[i]) begin
            next_st.regs.fb_lo[i] = hwdata[7:0];
          end
          if (st.dph_idx == PDC_IDX_ADDHI[i]) begin
            next_st.regs.add_hi[i] = hwdata[7:0];
          end
        end
        if (st.dph_idx == PDC_IDX_CTRL) begin
          next_st.regs.ctrl = hwdata[7:0] & PDC_CTRL_MASK;
        end
        if (st.dph_idx == PDC_IDX_SPREAD) begin
          next_st.regs.spread = hwdata[PDC_FRAC_W-1:0];
        end
      end
      next_st.dph_wr = aph && hwrite && mapped;
      next_st.dph_idx = aph_idx;
      next_st.hreadyout = 1'b1;
      next_st.hresp = 1'b0;
      if (aph && !hwrite && mapped) begin
        next_st.hrdata = pdc_read(next_st.regs, st.act_set, st.act, aph_idx);
      end else begin
        next_st.hrdata = 32'h0;
      end
      // set choice: pins, forced set zero, or the software field
      if (st.regs.ctrl[PDC_CTRL_SEL_EN]) begin
        pick = sel_pins;
      end else if (st.regs.ctrl[PDC_CTRL_MFC]) begin
        pick = PDC_SET_ZERO;
      end else begin
        pick = st.regs.ctrl[PDC_CTRL_SW_SET_LSB +: 2];
      end
      next_st.act_set = pick;
      next_st.act.prescaler = st.regs.pre[st.act_set];
      next_st.act.fb_int = cur_n;
      next_st.act.fb_adder = cur_a;
      next_st.act.pole_cap = cur_filt[PDC_POLE_LSB +: 4];
      next_st.act.zero_cap = cur_filt[PDC_ZERO_LSB +: 4];
      next_st.act.mult = cur_mult;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.hreadyout <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign pll1_active_set = st.act_set;
  assign pll1_active = st.act;

  // ****************************************
  // checks
  // ****************************************
  logic [PDC_MULT_W-1:0] chk_base;
  logic [PDC_MULT_W-1:0] chk_ss;
  logic [PDC_MULT_W-1:0] chk_plain;
  logic inactive_pre_wr;

  assign chk_base = PDC_MULT_W'(cur_n) + PDC_MULT_W'(cur_n) + PDC_MULT_W'(cur_a) + 20'h00001;
  assign chk_ss = (chk_base << PDC_FRAC_W) + PDC_MULT_W'(st.regs.spread);
  assign chk_plain = PDC_MULT_W'(cur_n) << (PDC_FRAC_W + 1);
  assign inactive_pre_wr = st.dph_wr && (st.dph_idx == PDC_IDX_PRE[0]
    || st.dph_idx == PDC_IDX_PRE[1] || st.dph_idx == PDC_IDX_PRE[2]
    || st.dph_idx == PDC_IDX_PRE[3])
    && (st.dph_idx != PDC_IDX_PRE[st.act_set]);

  for (genvar g = 0; g < PDC_SETS; g++) begin : g_pre_chk
    property p_pre_store;
      @(posedge hclk) disable iff (!hresetn)
      (ce && st.dph_wr && st.dph_idx == PDC_IDX_PRE[g])
        |=> (st.regs.pre[g] == $past(hwdata[7:0]));
    endproperty
    a_pre_store: assert property (p_pre_store)
      else $error("prescaler write not stored");
  end

  property p_mfc_zero;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !st.regs.ctrl[PDC_CTRL_SEL_EN] && st.regs.ctrl[PDC_CTRL_MFC])
      |=> (st.act_set == PDC_SET_ZERO);
  endproperty
  a_mfc_zero: assert property (p_mfc_zero)
    else $error("set zero not applied in mfc mode");

  property p_fb_int_live;
    @(posedge hclk) disable iff (!hresetn)
    ce |=> (st.act.fb_int == $past(cur_n)
      && st.act.prescaler == $past(st.regs.pre[st.act_set]));
  endproperty
  a_fb_int_live: assert property (p_fb_int_live)
    else $error("feedback integer does not follow the live set");

  property p_adder_live;
    @(posedge hclk) disable iff (!hresetn)
    ce |=> (st.act.fb_adder
      == $past(st.regs.add_hi[st.act_set][PDC_ADDER_LSB +: PDC_ADD_W]));
  endproperty
  a_adder_live: assert property (p_adder_live)
    else $error("adder does not follow the live set");

  property p_mult_spread;
    @(posedge hclk) disable iff (!hresetn)
    (ce && spread_on) |=> (st.act.mult == $past(chk_ss));
  endproperty
  a_mult_spread: assert property (p_mult_spread)
    else $error("spread multiplier wrong");

  property p_mult_no_add;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !spread_on && cur_a == 4'h0) |=> (st.act.mult == $past(chk_plain));
  endproperty
  a_mult_no_add: assert property (p_mult_no_add)
    else $error("multiplier not twice the integer value");

  property p_mult_add;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !spread_on && cur_a != 4'h0)
      |=> (st.act.mult == $past(chk_base << PDC_FRAC_W));
  endproperty
  a_mult_add: assert property (p_mult_add)
    else $error("multiplier with adder wrong");

  property p_spread_read;
    @(posedge hclk) disable iff (!hresetn)
    (ce && aph && !hwrite && mapped && aph_idx == PDC_IDX_SPREAD && !st.dph_wr)
      |=> (hrdata == {26'h0, $past(st.regs.spread)});
  endproperty
  a_spread_read: assert property (p_spread_read)
    else $error("spread offset readback wrong");

  sequence s_inactive_write;
    ce && inactive_pre_wr ##1 ce && !st.dph_wr && $stable(st.act_set);
  endsequence

  property p_inactive_quiet;
    @(posedge hclk) disable iff (!hresetn)
    s_inactive_write |=> $stable(st.act.prescaler);
  endproperty
  a_inactive_quiet: assert property (p_inactive_quiet)
    else $error("inactive set write disturbed live prescaler");

endmodule

// File: pkg/pdc_pkg.sv
package pdc_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [3:0][7:0] PDC_IDX_FILT = {8'h27, 8'h26, 8'h25, 8'h24};
  localparam logic [3:0][7:0] PDC_IDX_PRE = {8'h2b, 8'h2a, 8'h29, 8'h28};
  localparam logic [3:0][7:0] PDC_IDX_FBLO = {8'h2f, 8'h2e, 8'h2d, 8'h2c};
  localparam logic [3:0][7:0] PDC_IDX_ADDHI = {8'h34, 8'h32, 8'h31, 8'h30};
  localparam logic [7:0] PDC_IDX_CTRL = 8'h40;
  localparam logic [7:0] PDC_IDX_SPREAD = 8'h41;
  localparam logic [7:0] PDC_IDX_STAT = 8'h42;
  localparam logic [7:0] PDC_IDX_STAT2 = 8'h43;
  localparam int PDC_IDX_LSB = 2;
  localparam int PDC_IDX_MSB = 9;

  // ****************************************
  // field positions, masks and reset values
  // ****************************************
  localparam int PDC_CTRL_SEL_EN = 0;
  localparam int PDC_CTRL_MFC = 1;
  localparam int PDC_CTRL_SPREAD_EN = 2;
  localparam int PDC_CTRL_SW_SET_LSB = 4;
  localparam logic [7:0] PDC_CTRL_MASK = 8'h37;
  localparam int PDC_ADDER_LSB = 4;
  localparam int PDC_FBHI_LSB = 0;
  localparam int PDC_POLE_LSB = 4;
  localparam int PDC_ZERO_LSB = 0;
  localparam int PDC_STAT_SET_LSB = 24;
  localparam int PDC_STAT2_FILT_LSB = 8;
  localparam logic [7:0] PDC_BYTE_RST = 8'h00;
  localparam logic [5:0] PDC_SPREAD_RST = 6'h00;
  localparam logic [1:0] PDC_SET_ZERO = 2'h0;

  // ****************************************
  // widths
  // ****************************************
  localparam int PDC_SETS = 4;
  localparam int PDC_FB_W = 12;
  localparam int PDC_ADD_W = 4;
  localparam int PDC_FRAC_W = 6;
  localparam int PDC_MULT_W = 20;
  localparam int PDC_SEL_W = 2;

  typedef struct packed {
    logic [7:0] prescaler;
    logic [PDC_FB_W-1:0] fb_int;
    logic [PDC_ADD_W-1:0] fb_adder;
    logic [3:0] pole_cap;
    logic [3:0] zero_cap;
    logic [PDC_MULT_W-1:0] mult;
  } pdc_active_t;

  typedef struct packed {
    logic [3:0][7:0] filt;
    logic [3:0][7:0] pre;
    logic [3:0][7:0] fb_lo;
    logic [3:0][7:0] add_hi;
    logic [7:0] ctrl;
    logic [5:0] spread;
  } pdc_regs_t;

  typedef struct packed {
    pdc_regs_t regs;
    logic [1:0] act_set;
    pdc_active_t act;
    logic dph_wr;
    logic [7:0] dph_idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } pdc_state_t;

endpackage

// File: src/pdc_sync2.sv
`timescale 1ns/100ps
module pdc_sync2 #(
  parameter int W = 2
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // stage 0 feeds only stage 1
  logic [1:0][W-1:0] st;
  logic [1:0][W-1:0] next_st;

  if (W < 1) begin : g_bad_w
    $error("pdc_sync2: width must be at least one");
  end

  always_comb begin
    next_st = st;
    if (ce) begin
      next_st[0] = d;
      next_st[1] = st[0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st[1];
endmodule

// File: src/pdc_mult_calc.sv
`timescale 1ns/100ps
module pdc_mult_calc
  import pdc_pkg::*;
#(
  parameter int NW = PDC_FB_W,
  parameter int AW = PDC_ADD_W,
  parameter int FW = PDC_FRAC_W,
  parameter int MW = PDC_MULT_W
) (
  input wire logic [NW-1:0] fb_int,
  input wire logic [AW-1:0] fb_adder,
  input wire logic spread_en,
  input wire logic [FW-1:0] spread_off,
  output logic [MW-1:0] mult
);
  // result is fixed point with FW fraction bits; 2n + a + 1 needs NW + 2 integer bits
  if (MW < NW + FW + 2 || AW > NW + 1) begin : g_bad_mw
    $error("pdc_mult_calc: result too narrow");
  end

  logic [MW-1:0] twice_n;
  logic [MW-1:0] base;

  always_comb begin
    twice_n = MW'({fb_int, 1'b0});
    base = twice_n + MW'(fb_adder) + MW'(1'b1);
    if (!spread_en && fb_adder == '0) begin
      mult = twice_n << FW;
    end else if (spread_en) begin
      mult = (base << FW) + MW'(spread_off);
    end else begin
      mult = base << FW;
    end
  end
endmodule

// File: bench/testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module testbench
  import pdc_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] pins = 2'h0;
  logic ce = 1'b1;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [1:0] act_set;
  pdc_active_t act;
  logic [7:0] vals [4][4];
  logic [31:0] rd_v;
  int fails = 0;
  int n_compared = 0;

  always #2.5 hclk = ~hclk;

  // single slave, so its ready is the bus ready
  pdc_config_bank u_pdc_config_bank (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .config_select_inputs(pins), .pll1_active_set(act_set), .pll1_active(act)
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    `CHK(hresp, 1'b0);
    hsel <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus({22'h0, idx, 2'h0}, 1'b1, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] q);
    bus({22'h0, idx, 2'h0}, 1'b0, 32'h0, q);
  endtask

  function automatic logic [7:0] ridx(input int k, input int s);
    case (k)
      0: return PDC_IDX_PRE[s];
      1: return PDC_IDX_FBLO[s];
      2: return PDC_IDX_ADDHI[s];
      default: return PDC_IDX_FILT[s];
    endcase
  endfunction

  // live values follow a write within four edges
  task automatic settle();
    repeat (6) @(posedge hclk);
  endtask

  task automatic chk_act(input int s, input logic sp, input logic [5:0] off);
    logic [11:0] n;
    logic [3:0] a;
    logic [19:0] m;
    n = {vals[2][s][3:0], vals[1][s]};
    a = vals[2][s][7:4];
    m = (!sp && a == 4'h0) ? 20'(n * 128) : 20'((2 * n + a + 1) * 64 + off);
    `CHK(act_set, s);
    `CHK(act.prescaler, vals[0][s]);
    `CHK(act.fb_int, n);
    `CHK(act.fb_adder, a);
    `CHK({act.pole_cap, act.zero_cap}, vals[3][s]);
    `CHK(act.mult, m);
    rd(PDC_IDX_STAT, rd_v);
    `CHK(rd_v, {6'h0, 2'(s), 4'h0, m});
    rd(PDC_IDX_STAT2, rd_v);
    `CHK(rd_v, {16'h0, vals[3][s], vals[0][s]});
  endtask

  task automatic stop_test();
    $display("compared %0d values, %0d wrong", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    for (int s = 0; s < 4; s++) begin
      vals[0][s] = 8'h5a + 8'(s);
      vals[1][s] = 8'h93 - 8'(s * 16);
      // set 0 keeps a zero adder, set 3 the largest one
      vals[2][s] = {4'(s * 5), 4'(s + 8)};
      vals[3][s] = 8'hc6 + 8'(s * 17);
    end
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 4; s++) begin
        rd(ridx(k, s), rd_v);
        `CHK(rd_v, 32'h0);
      end
    end
    `CHK(act_set, 2'h0);
    `CHK(act.mult, 20'h0);
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 4; s++) begin
        wr(ridx(k, s), {24'h0, vals[k][s]});
      end
    end
    for (int k = 0; k < 4; k++) begin
      for (int s = 0; s < 4; s++) begin
        rd(ridx(k, s), rd_v);
        `CHK(rd_v, {24'h0, vals[k][s]});
      end
    end
    $display("test readback done");
    for (int s = 0; s < 4; s++) begin
      wr(PDC_IDX_CTRL, 32'(s << PDC_CTRL_SW_SET_LSB));
      settle();
      chk_act(s, 1'b0, 6'h0);
    end
    $display("test set multipliers done");
    wr(PDC_IDX_SPREAD, 32'hffff_ff2b);
    rd(PDC_IDX_SPREAD, rd_v);
    `CHK(rd_v, 32'h2b);
    wr(PDC_IDX_CTRL, 32'h04);
    settle();
    chk_act(0, 1'b1, 6'h2b);
    wr(PDC_IDX_CTRL, 32'h34);
    settle();
    chk_act(3, 1'b1, 6'h2b);
    $display("test spread offset done");
    wr(PDC_IDX_CTRL, 32'h32);
    settle();
    chk_act(0, 1'b0, 6'h0);
    pins <= 2'h2;
    wr(PDC_IDX_CTRL, 32'h33);
    settle();
    chk_act(2, 1'b0, 6'h0);
    pins <= 2'h1;
    settle();
    chk_act(1, 1'b0, 6'h0);
    $display("test select modes done");
    // a low enable freezes the synchroniser and the live set
    ce <= 1'b0;
    pins <= 2'h3;
    settle();
    `CHK(act_set, 2'h1);
    ce <= 1'b1;
    settle();
    chk_act(3, 1'b0, 6'h0);
    $display("test clock enable done");
    // writes to an idle set must not disturb the live one
    wr(PDC_IDX_CTRL, 32'h10);
    wr(PDC_IDX_PRE[2], 32'h3c);
    wr(PDC_IDX_FBLO[0], 32'h01);
    settle();
    chk_act(1, 1'b0, 6'h0);
    vals[0][1] = 8'he1;
    wr(PDC_IDX_PRE[1], 32'he1);
    settle();
    chk_act(1, 1'b0, 6'h0);
    $display("test inactive writes done");
    wr(8'h35, 32'hff);
    rd(8'h35, rd_v);
    `CHK(rd_v, 32'h0);
    bus(32'h0000_10a4, 1'b0, 32'h0, rd_v);
    `CHK(rd_v, 32'h0);
    wr(PDC_IDX_CTRL, 32'hffff_ffff);
    rd(PDC_IDX_CTRL, rd_v);
    `CHK(rd_v, {24'h0, PDC_CTRL_MASK});
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd(PDC_IDX_PRE[1], rd_v);
    `CHK(rd_v, 32'h0);
    $display("test unmapped and reset done");
    stop_test();
  end

  // the tests need a few hundred cycles at most
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    stop_test();
  end
endmodule
